// ==== hw/mptrl_cnt_if.sv ====
// Load and readback signals of one pause down counter.
// Driven by the top module on core_clk; no clocking of its own.
`timescale 1ns/1ns
interface mptrl_cnt_if;
  logic load;
  logic [15:0] operand;
  logic [11:0] slot_cycles;
  logic [15:0] count;
  logic busy;
  modport ctl (output load, output operand, output slot_cycles, input count, input busy);
  modport cnt (input load, input operand, input slot_cycles, output count, output busy);
endinterface

// ==== hw/mptrl_pause_cnt.sv ====
// One pause down counter, decremented once per slot time.
// Assumes load is a one-cycle pulse on core_clk and slot_cycles is nonzero.
`timescale 1ns/1ns
module mptrl_pause_cnt import mptrl_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Counter link
  mptrl_cnt_if.cnt cif
);

  mptrl_cnt_state_t state_r;
  logic [CNT_W-1:0] count_r;
  logic [PRE_W-1:0] pre_r;
  logic tick;

  // Prescaler restarts on load so the first slot is a whole one
  assign tick = (state_r == MPTRL_RUN) && (pre_r == PRE_W'(cif.slot_cycles - 12'h001));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pre_r <= RST_PRE;
    end else if (cif.load || tick || state_r != MPTRL_RUN) begin
      pre_r <= RST_PRE;
    end else begin
      pre_r <= pre_r + 12'h001;
    end
  end

  // Run while a nonzero count remains; a reload wins over the last tick
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= MPTRL_IDLE;
    end else if (cif.load) begin
      state_r <= (cif.operand != RST_CNT) ? MPTRL_RUN : MPTRL_IDLE;
    end else begin
      case (state_r)
        MPTRL_IDLE: state_r <= MPTRL_IDLE;
        MPTRL_RUN: begin
          if (tick && count_r == 16'h0001) begin
            state_r <= MPTRL_IDLE;
          end
        end
        default: state_r <= MPTRL_IDLE;
      endcase
    end
  end

  // One unit per slot, stopping at zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_r <= RST_CNT;
    end else if (cif.load) begin
      count_r <= cif.operand;
    end else if (tick && count_r != RST_CNT) begin
      count_r <= count_r - 16'h0001;
    end
  end

  assign cif.count = count_r;
  assign cif.busy = (state_r == MPTRL_RUN);

endmodule

// ==== hw/mptrl_pkg.sv ====
// Constants shared by the pause timer and length/type capture block.
// Assumes a 50 MHz core clock and a 32-bit classic Wishbone register bus.
package mptrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [31:0] ADR_RX_PAUSE_OPERAND = 32'hFFF030BC;
  localparam logic [31:0] ADR_RX_PAUSE_REMAINING = 32'hFFF030C0;
  localparam logic [31:0] ADR_TX_PAUSE_REMAINING = 32'hFFF030C4;
  localparam logic [31:0] ADR_RX_LENGTH_TYPE_STATUS = 32'hFFF030C8;
  localparam logic [31:0] ADR_MAC_COMMAND = 32'hFFF030E0;
  localparam logic [31:0] ADR_MAC_INTERRUPT_ENABLE = 32'hFFF030E4;
  localparam logic [31:0] ADR_MAC_INTERRUPT_STATUS = 32'hFFF030E8;
  localparam logic [31:0] ADR_MAC_STATUS = 32'hFFF030EC;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CMD_SEND_PAUSE_BIT = 0;
  localparam int CMD_FULL_DUPLEX_BIT = 1;
  localparam int CMD_SPEED_100_BIT = 2;
  localparam int IRQ_LENGTH_TYPE_BIT = 0;
  localparam int IRQ_CTRL_FRAME_BIT = 1;
  localparam int STAT_TX_PAUSED_BIT = 0;
  localparam int CMD_W = 3;
  localparam int IRQ_W = 2;
  localparam int CNT_W = 16;
  localparam int PRE_W = 12;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] RST_REG32 = 32'h00000000;
  localparam logic [CMD_W-1:0] RST_CMD = 3'h0;
  localparam logic [IRQ_W-1:0] RST_IRQ = 2'h0;
  localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;
  localparam logic [PRE_W-1:0] RST_PRE = 12'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Slot time: 512 bit times, converted to core clock cycles
  localparam int SLOT_BITS = 512;
  localparam int CLK_PERIOD_NS = 20;
  localparam int BIT_NS_10M = 100;
  localparam int BIT_NS_100M = 10;
  localparam logic [PRE_W-1:0] SLOT_CYC_10M =
    PRE_W'((SLOT_BITS * BIT_NS_10M) / CLK_PERIOD_NS);
  localparam logic [PRE_W-1:0] SLOT_CYC_100M =
    PRE_W'((SLOT_BITS * BIT_NS_100M) / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // Down counter states
  typedef enum logic [1:0] {
    MPTRL_IDLE = 2'b01,
    MPTRL_RUN = 2'b10
  } mptrl_cnt_state_t;

endpackage

// ==== hw/mptrl_top.sv ====
// Flow-control pause timers and received length/type capture of a MAC.
// Assumes frame engines on core_clk give one-cycle event pulses with data.
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ns

module mptrl_top import mptrl_pkg::*; (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Receive engine events
  input wire logic rx_pause_valid,
  input wire logic [15:0] rx_pause_operand_in,
  input wire logic rx_length_type_valid,
  input wire logic [15:0] rx_length_type_field,
  // Transmit engine handshake
  input wire logic tx_pause_done,
  input wire logic [15:0] tx_pause_operand_in,
  output logic send_pause_req,
  output logic tx_paused_flag,
  // Interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic ack_r;
  logic [31:0] dat_r;
  logic [31:0] rdata;
  logic [31:0] wmask;
  logic req;
  logic wr_fire;
  logic [CMD_W-1:0] cmd_r;
  logic send_pause_r;
  logic [IRQ_W-1:0] irq_en_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic irq_r;
  logic tx_hold_r;
  logic [CNT_W-1:0] operand_r;
  logic [CNT_W-1:0] lt_r;
  logic full_duplex;
  logic rx_pause_take;
  logic [PRE_W-1:0] slot_cyc;
  logic [1:0] load_w;
  logic [CNT_W-1:0] op_w [2];
  logic [CNT_W-1:0] cnt_w [2];
  logic [1:0] busy_w;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, writes land on the acked edge
  assign req = wb_cyc_i && wb_stb_i;
  assign wr_fire = req && wb_we_i && ack_r;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Ack drops the cycle after it was given
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  // Read data sampled with the ack; unmapped addresses read zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dat_r <= RST_REG32;
    end else if (req && !ack_r && !wb_we_i) begin
      dat_r <= rdata;
    end
  end

  // Read mux; reserved bits read zero
  always_comb begin
    rdata = RST_REG32;
    case (wb_adr_i)
      ADR_RX_PAUSE_OPERAND: rdata = {16'h0000, operand_r};
      ADR_RX_PAUSE_REMAINING: rdata = {16'h0000, cnt_w[0]};
      ADR_TX_PAUSE_REMAINING: rdata = {16'h0000, cnt_w[1]};
      ADR_RX_LENGTH_TYPE_STATUS: rdata = {16'h0000, lt_r};
      ADR_MAC_COMMAND: rdata = {29'h00000000, cmd_r[2:1], send_pause_r};
      ADR_MAC_INTERRUPT_ENABLE: rdata = {30'h00000000, irq_en_r};
      ADR_MAC_INTERRUPT_STATUS: rdata = {30'h00000000, irq_stat_r};
      ADR_MAC_STATUS: rdata = {31'h00000000, tx_hold_r};
      default: rdata = RST_REG32;
    endcase
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  ////////////////////////////////////////////////////////////////////////////
  // Command and enable registers
  assign full_duplex = cmd_r[CMD_FULL_DUPLEX_BIT];
  assign slot_cyc = cmd_r[CMD_SPEED_100_BIT] ? SLOT_CYC_100M : SLOT_CYC_10M;

  // Duplex and speed bits; bit 0 lives in send_pause_r
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmd_r <= RST_CMD;
    end else if (wr_fire && wb_adr_i == ADR_MAC_COMMAND && wb_sel_i[0]) begin
      cmd_r <= wb_dat_i[CMD_W-1:0];
    end
  end

  // Send-pause command: a write of one sets, frame completion clears
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      send_pause_r <= 1'b0;
    end else if (wr_fire && wb_adr_i == ADR_MAC_COMMAND && wb_sel_i[0]
                 && wb_dat_i[CMD_SEND_PAUSE_BIT]) begin
      send_pause_r <= 1'b1;
    end else if (tx_pause_done) begin
      send_pause_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_en_r <= RST_IRQ;
    end else if (wr_fire && wb_adr_i == ADR_MAC_INTERRUPT_ENABLE && wb_sel_i[0]) begin
      irq_en_r <= wb_dat_i[IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pause counters: channel 0 received pause, channel 1 remote pause
  // Pause frames are only honoured in full duplex, as in 802.3x
  assign rx_pause_take = rx_pause_valid && full_duplex;
  assign load_w = {tx_pause_done, rx_pause_take};
  assign op_w[0] = rx_pause_operand_in;
  assign op_w[1] = tx_pause_operand_in;

  for (genvar ch = 0; ch < 2; ch++) begin : gen_ch
    mptrl_cnt_if cif ();
    assign cif.load = load_w[ch];
    assign cif.operand = op_w[ch];
    assign cif.slot_cycles = slot_cyc;
    assign cnt_w[ch] = cif.count;
    assign busy_w[ch] = cif.busy;
    mptrl_pause_cnt u_mptrl_pause_cnt (
      .core_clk(core_clk),
      .rst(rst),
      .cif(cif)
    );
  end

  // Operand register has no bus write path at all
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      operand_r <= RST_CNT;
    end else if (rx_pause_take) begin
      operand_r <= rx_pause_operand_in;
    end
  end

  // Transmitter held while sending pause or while received pause runs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_hold_r <= 1'b0;
    end else begin
      tx_hold_r <= busy_w[0] || send_pause_r;
    end
  end

  assign send_pause_req = send_pause_r;
  assign tx_paused_flag = tx_hold_r;

  ////////////////////////////////////////////////////////////////////////////
  // Length/type status: capture wins over a clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lt_r <= RST_CNT;
    end else if (rx_length_type_valid) begin
      lt_r <= rx_length_type_field;
    end else if (wr_fire && wb_adr_i == ADR_RX_LENGTH_TYPE_STATUS) begin
      lt_r <= lt_r & ~(wb_dat_i[15:0] & wmask[15:0]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear, set beats clear
  assign irq_set[IRQ_LENGTH_TYPE_BIT] = rx_length_type_valid && irq_en_r[IRQ_LENGTH_TYPE_BIT];
  assign irq_set[IRQ_CTRL_FRAME_BIT] = rx_pause_take;
  assign irq_clr = (wr_fire && wb_adr_i == ADR_MAC_INTERRUPT_STATUS && wb_sel_i[0])
                   ? wb_dat_i[IRQ_W-1:0] : RST_IRQ;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_stat_r <= RST_IRQ;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
    end
  end

  // Level output, one cycle behind status
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end

  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // Helper: cycles since the last load or change of the received pause count
  logic [PRE_W-1:0] gap_r;
  logic [CNT_W-1:0] cnt0_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gap_r <= RST_PRE;
      cnt0_q <= RST_CNT;
    end else begin
      cnt0_q <= cnt_w[0];
      gap_r <= load_w[0] ? RST_PRE : (cnt_w[0] != cnt0_q) ? 12'h001 : gap_r + 12'h001;
    end
  end

  sequence s_lt_enabled;
    rx_length_type_valid && irq_en_r[IRQ_LENGTH_TYPE_BIT];
  endsequence
  sequence s_flag_then_irq;
    irq_stat_r[IRQ_LENGTH_TYPE_BIT] ##1 irq;
  endsequence

  AST_OPERAND_CAPTURE: assert property (
    rx_pause_take |=> operand_r == $past(rx_pause_operand_in))
    else $error("pause operand not captured");
  AST_OPERAND_HELD: assert property (
    busy_w[0] && !rx_pause_take |=> $stable(operand_r))
    else $error("operand changed during pause");
  AST_SLOT_LENGTH: assert property (
    (cnt_w[0] == cnt0_q - 16'h0001) && !$past(load_w[0]) |-> gap_r == slot_cyc)
    else $error("slot length wrong");
  AST_COUNT_LOAD: assert property (
    rx_pause_take |=> cnt_w[0] == $past(rx_pause_operand_in) && busy_w[0] == (cnt_w[0] != 0))
    else $error("receive counter not loaded");
  AST_RELOAD: assert property (
    busy_w[0] && rx_pause_take |=> cnt_w[0] == $past(rx_pause_operand_in))
    else $error("running counter not reloaded");
  AST_REMOTE_START: assert property (
    !tx_pause_done && !busy_w[1] |=> cnt_w[1] == RST_CNT || $past(cnt_w[1]) == cnt_w[1])
    else $error("remote counter started without frame");
  AST_RO_IGNORED: assert property (
    wr_fire && wb_adr_i == ADR_RX_PAUSE_OPERAND && !rx_pause_take |=> $stable(operand_r))
    else $error("read-only register written");
  AST_LT_CAPTURE: assert property (
    rx_length_type_valid |=> lt_r == $past(rx_length_type_field))
    else $error("length/type not captured");
  AST_LT_CLEAR: assert property (
    wr_fire && wb_adr_i == ADR_RX_LENGTH_TYPE_STATUS && !rx_length_type_valid
    |=> lt_r == ($past(lt_r) & ~($past(wb_dat_i[15:0]) & $past(wmask[15:0]))))
    else $error("write-one-clear wrong");
  AST_LT_IRQ: assert property (
    s_lt_enabled |=> s_flag_then_irq)
    else $error("length/type interrupt missing");
  AST_SEND_PAUSE: assert property (
    send_pause_r |=> tx_hold_r)
    else $error("transmitter not paused for send");
  AST_CTRL_FLAG_DUPLEX: assert property (
    $rose(irq_stat_r[IRQ_CTRL_FRAME_BIT]) |-> $past(rx_pause_valid && full_duplex))
    else $error("control frame flag outside full duplex");
  AST_RESUME: assert property (
    !busy_w[0] && !send_pause_r |=> !tx_hold_r)
    else $error("transmit not resumed at zero");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the bus answer and the corners of the pause rules

  // A request taken on an idle edge, then a single ack pulse
  sequence s_bus_taken;
    req && !ack_r;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  // Pause frame accepted with a nonzero operand, then busy, then hold
  sequence s_nonzero_pause;
    rx_pause_take && rx_pause_operand_in != RST_CNT;
  endsequence
  sequence s_busy_then_hold;
    busy_w[0] ##1 tx_paused_flag;
  endsequence

  // Master holds the request, so the slave owes exactly one wait state
  AST_ACK_ONE_WAIT: assert property (
    s_bus_taken |=> s_ack_pulse)
    else $error("bus ack not a single pulse after one wait");

  // Read data stands with the ack and shows the addressed register
  AST_READ_DATA: assert property (
    s_bus_taken && !wb_we_i |=> wb_dat_o == $past(rdata))
    else $error("read data not presented with ack");

  // Remote counter loads the operand of the frame just sent
  AST_REMOTE_LOAD: assert property (
    tx_pause_done |=> cnt_w[1] == $past(tx_pause_operand_in))
    else $error("remote counter not loaded after own pause");

  // Half duplex: a pause frame leaves operand and flag alone
  AST_HALF_DUPLEX_REFUSED: assert property (
    rx_pause_valid && !full_duplex
    |=> $stable(operand_r) && !$rose(irq_stat_r[IRQ_CTRL_FRAME_BIT]))
    else $error("pause frame taken in half duplex");

  // Send-pause request drops once the frame is out, unless set again
  AST_SEND_CLEAR: assert property (
    tx_pause_done && !(wr_fire && wb_adr_i == ADR_MAC_COMMAND && wb_sel_i[0]
    && wb_dat_i[CMD_SEND_PAUSE_BIT]) |=> !send_pause_req)
    else $error("send-pause request not cleared");

  // Transmitter held two cycles after a nonzero pause is taken
  AST_HOLD_AFTER_LOAD: assert property (
    s_nonzero_pause |=> s_busy_then_hold)
    else $error("transmitter not held after pause load");

  // Interrupt level follows unmasked status with one cycle of lag
  AST_IRQ_LEVEL: assert property (
    irq == $past(|(irq_stat_r & irq_en_r)))
    else $error("interrupt level wrong");

  // Idle counters stay at zero: no wrap below zero
  AST_COUNT_FLOOR: assert property (
    cnt_w[0] == RST_CNT && !load_w[0] |=> cnt_w[0] == RST_CNT)
    else $error("receive pause counter wrapped");
  AST_REMOTE_FLOOR: assert property (
    cnt_w[1] == RST_CNT && !load_w[1] |=> cnt_w[1] == RST_CNT)
    else $error("remote pause counter wrapped");

endmodule

// ==== verification/mptrl_partner.sv ====
// Far-side frame engines: receive event source and the pause transmitter.
// Assumes core_clk from the bench; receive tasks are called by the bench.
`timescale 1ns/1ns
module mptrl_partner import mptrl_pkg::*; #(
  parameter int TX_DELAY = 20,
  parameter logic [15:0] TX_OP = 16'h0002
) (
  // Clock
  input wire logic core_clk,
  // Receive events
  output logic rx_pause_valid,
  output logic [15:0] rx_pause_operand_in,
  output logic rx_length_type_valid,
  output logic [15:0] rx_length_type_field,
  // Transmit handshake
  input wire logic send_pause_req,
  output logic tx_pause_done,
  output logic [15:0] tx_pause_operand_in
);
  ////////////////////////////////////////////////////////////////////////////
  // One-cycle pause frame; data inverted after so stale values never match
  task automatic rx_pause(input logic [15:0] op);
    @(posedge core_clk);
    rx_pause_valid <= 1'b1;
    rx_pause_operand_in <= op;
    @(posedge core_clk);
    rx_pause_valid <= 1'b0;
    rx_pause_operand_in <= ~op;
  endtask

  // One-cycle length/type field
  task automatic rx_lt(input logic [15:0] f);
    @(posedge core_clk);
    rx_length_type_valid <= 1'b1;
    rx_length_type_field <= f;
    @(posedge core_clk);
    rx_length_type_valid <= 1'b0;
    rx_length_type_field <= ~f;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Own pause frame goes out some cycles after the request
  initial begin
    rx_pause_valid = 1'b0;
    rx_pause_operand_in = 16'h5A5A;
    rx_length_type_valid = 1'b0;
    rx_length_type_field = 16'hA5A5;
    tx_pause_done = 1'b0;
    tx_pause_operand_in = ~TX_OP;
    forever begin
      @(posedge core_clk);
      if (send_pause_req === 1'b1) begin
        repeat (TX_DELAY) @(posedge core_clk);
        tx_pause_done <= 1'b1;
        tx_pause_operand_in <= TX_OP;
        @(posedge core_clk);
        tx_pause_done <= 1'b0;
        tx_pause_operand_in <= ~TX_OP;
        @(posedge core_clk);
      end
    end
  end
endmodule

// ==== verification/mptrl_top_tb.sv ====
// Bench for the pause timers and length/type capture, over Wishbone.
// Assumes the partner model drives every frame engine input.
`timescale 1ns/1ns
module mptrl_top_tb import mptrl_pkg::*; ;
  logic core_clk;
  logic rst = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [31:0] wb_adr = 32'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, rpv, ltv, tpd, send_pause_req, tx_paused_flag, irq;
  logic [15:0] rpo, ltf, tpo;
  int n_tests = 0;
  int n_mismatch = 0;

  mptrl_top u_mptrl_top (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_pause_valid(rpv),
    .rx_pause_operand_in(rpo), .rx_length_type_valid(ltv), .rx_length_type_field(ltf),
    .tx_pause_done(tpd), .tx_pause_operand_in(tpo), .send_pause_req(send_pause_req),
    .tx_paused_flag(tx_paused_flag), .irq(irq));
  mptrl_partner u_mptrl_partner (.core_clk(core_clk), .rx_pause_valid(rpv),
    .rx_pause_operand_in(rpo), .rx_length_type_valid(ltv), .rx_length_type_field(ltf),
    .send_pause_req(send_pause_req), .tx_pause_done(tpd), .tx_pause_operand_in(tpo));

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic cycle; ack and data read just before the edge's own updates land
  task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int k;
    @(posedge core_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= 4'hF;
    wb_dat <= d;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 16);
    if (k >= 16) begin
      n_mismatch++;
      $display("ERROR ack expected 1 seen none");
      wrap_up();
    end
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // Bounded wait for the transmitter to be released
  task automatic wait_unpaused(input int lim);
    int k;
    k = 0;
    while (tx_paused_flag !== 1'b0 && k < lim) begin
      @(posedge core_clk);
      k++;
    end
    if (k >= lim) begin
      n_mismatch++;
      $display("ERROR tx_paused expected 0 seen 1");
      wrap_up();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    $display("ERROR run expected end seen timeout");
    wrap_up();
  end

  // Main sequence; 100M speed keeps a slot at 256 cycles
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    rd(ADR_RX_PAUSE_OPERAND, RST_REG32, "operand");
    rd(ADR_RX_PAUSE_REMAINING, RST_REG32, "rx_remaining");
    rd(ADR_TX_PAUSE_REMAINING, RST_REG32, "tx_remaining");
    rd(ADR_RX_LENGTH_TYPE_STATUS, RST_REG32, "lt_status");
    rd(32'hFFF030D0, 32'h00000000, "unmapped");
    $display("test reset done");
    wr(ADR_MAC_COMMAND, 32'h00000006);
    u_mptrl_partner.rx_lt(16'h0800);
    rd(ADR_RX_LENGTH_TYPE_STATUS, 32'h00000800, "lt_status");
    rd(ADR_MAC_INTERRUPT_STATUS, 32'h00000000, "int_status");
    wr(ADR_MAC_INTERRUPT_ENABLE, 32'h00000001);
    u_mptrl_partner.rx_lt(16'hABCD);
    rd(ADR_RX_LENGTH_TYPE_STATUS, 32'h0000ABCD, "lt_status");
    rd(ADR_MAC_INTERRUPT_STATUS, 32'h00000001, "int_status");
    chk("irq", 32'h1, {31'h0, irq});
    wr(ADR_RX_LENGTH_TYPE_STATUS, 32'h000000FF);
    rd(ADR_RX_LENGTH_TYPE_STATUS, 32'h0000AB00, "lt_status");
    wr(ADR_MAC_INTERRUPT_ENABLE, 32'h00000000);
    rd(ADR_MAC_INTERRUPT_STATUS, 32'h00000001, "int_status");
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(ADR_MAC_INTERRUPT_ENABLE, 32'h00000001);
    wr(ADR_MAC_INTERRUPT_STATUS, 32'h00000001);
    rd(ADR_MAC_INTERRUPT_STATUS, 32'h00000000, "int_status");
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test length_type done");
    wr(ADR_MAC_INTERRUPT_ENABLE, 32'h00000003);
    u_mptrl_partner.rx_pause(16'h0003);
    rd(ADR_RX_PAUSE_OPERAND, 32'h00000003, "operand");
    rd(ADR_RX_PAUSE_REMAINING, 32'h00000003, "rx_remaining");
    rd(ADR_MAC_INTERRUPT_STATUS, 32'h00000002, "int_status");
    chk("irq ctrl", 32'h1, {31'h0, irq});
    chk("tx_paused", 32'h1, {31'h0, tx_paused_flag});
    repeat (300) @(posedge core_clk);
    rd(ADR_RX_PAUSE_REMAINING, 32'h00000002, "rx_remaining");
    u_mptrl_partner.rx_pause(16'h0005);
    rd(ADR_RX_PAUSE_REMAINING, 32'h00000005, "rx_remaining");
    wr(ADR_RX_PAUSE_OPERAND, 32'h0000FFFF);
    wr(ADR_RX_PAUSE_REMAINING, 32'h0000FFFF);
    rd(ADR_RX_PAUSE_REMAINING, 32'h00000005, "rx_remaining");
    repeat (1000) @(posedge core_clk);
    rd(ADR_RX_PAUSE_OPERAND, 32'h00000005, "operand");
    chk("tx_paused", 32'h1, {31'h0, tx_paused_flag});
    wait_unpaused(400);
    rd(ADR_RX_PAUSE_REMAINING, 32'h00000000, "rx_remaining");
    $display("test rx_pause done");
    wr(ADR_MAC_INTERRUPT_STATUS, 32'h00000002);
    wr(ADR_MAC_COMMAND, 32'h00000004);
    u_mptrl_partner.rx_pause(16'h0007);
    rd(ADR_RX_PAUSE_OPERAND, 32'h00000005, "operand");
    rd(ADR_MAC_INTERRUPT_STATUS, 32'h00000000, "int_status");
    chk("irq refused", 32'h0, {31'h0, irq});
    $display("test half_duplex done");
    wr(ADR_MAC_COMMAND, 32'h00000007);
    rd(ADR_TX_PAUSE_REMAINING, 32'h00000000, "tx_remaining");
    chk("send_pause_req", 32'h1, {31'h0, send_pause_req});
    chk("tx_paused", 32'h1, {31'h0, tx_paused_flag});
    repeat (30) @(posedge core_clk);
    rd(ADR_TX_PAUSE_REMAINING, 32'h00000002, "tx_remaining");
    chk("send_pause_req", 32'h0, {31'h0, send_pause_req});
    wr(ADR_TX_PAUSE_REMAINING, 32'h00000009);
    rd(ADR_TX_PAUSE_REMAINING, 32'h00000002, "tx_remaining");
    $display("test send_pause done");
    // 10M speed: one slot is 2560 cycles
    wr(ADR_MAC_COMMAND, 32'h00000002);
    u_mptrl_partner.rx_pause(16'h0001);
    repeat (2000) @(posedge core_clk);
    rd(ADR_RX_PAUSE_REMAINING, 32'h00000001, "rx_remaining");
    wait_unpaused(700);
    rd(ADR_RX_PAUSE_REMAINING, 32'h00000000, "rx_remaining");
    $display("test slow_slot done");
    wrap_up();
  end
endmodule
